// File: src/spp_pad_map.sv
`timescale 1ns/100ps
module spp_pad_map
  import spp_pkg::*;
(
  // Register state
  input  wire logic [SPP_PINS-1:0] data_in,
  input  wire logic [SPP_PINS-1:0] dir_in,
  input  wire logic [SPP_PINS-1:0] pull_in,
  input  wire logic [SPP_PINS-1:0] slew_in,
  input  wire logic [SPP_PINS-1:0] drive_in,
  input  wire logic [SPP_PINS-1:0] irq_pd_in,
  // Pad controls
  output spp_pad_ctl_t             pad_out
);
  always_comb begin
    pad_out.out_en    = dir_in;
    pad_out.out_val   = data_in & dir_in;
    pad_out.pull_up   = pull_in & ~dir_in & ~irq_pd_in;
    pad_out.pull_down = pull_in & ~dir_in & irq_pd_in;
    pad_out.slew      = slew_in & dir_in;
    pad_out.drive_hi  = drive_in & dir_in;
  end
endmodule : spp_pad_map

// File: src/spp_pkg.sv
package spp_pkg;
  localparam int          SPP_PINS      = 6;
  localparam int          SPP_AW        = 3;
  localparam int          SPP_DW        = 8;
  // Register indices; the word offsets are a local choice
  localparam logic [2:0]  SPP_A_DATA    = 3'h0;
  localparam logic [2:0]  SPP_A_DIR     = 3'h1;
  localparam logic [2:0]  SPP_A_PULL    = 3'h2;
  localparam logic [2:0]  SPP_A_SLEW    = 3'h3;
  localparam logic [2:0]  SPP_A_DRIVE   = 3'h4;
  localparam logic [2:0]  SPP_A_IRQCFG  = 3'h5;
  localparam logic [5:0]  SPP_RST_ZERO  = 6'h00;
  // Slew default is a local choice; software must set it anyway
  localparam logic [5:0]  SPP_RST_SLEW  = 6'h00;
  localparam logic [7:0]  SPP_RD_NONE   = 8'h00;
  localparam logic        SPP_DRV_LOW   = 1'b0;
  localparam logic        SPP_DRV_HIGH  = 1'b1;

  typedef struct packed {
    logic [SPP_AW-1:0] addr;
    logic [SPP_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } spp_bus_req_t;

  typedef struct packed {
    logic [SPP_PINS-1:0] out_val;
    logic [SPP_PINS-1:0] out_en;
    logic [SPP_PINS-1:0] pull_up;
    logic [SPP_PINS-1:0] pull_down;
    logic [SPP_PINS-1:0] slew;
    logic [SPP_PINS-1:0] drive_hi;
  } spp_pad_ctl_t;
endpackage : spp_pkg

// File: src/spp_port.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - Direction bits read/write; zero turns driver off, data read returns pin.
// - Direction one enables driver; data read returns latched output value.
// - Pull-enable bit switches pull-up of an input pin with its IRQCFG bit clear.
// - Output pins ignore pull-enable; pull device held off.
// - Pull-down only on an input pin with pull-enable and its IRQCFG bit set.
// - Slew bit enables output slew limiting; no effect on inputs.
// - Drive bit selects low or high drive; ignored for inputs.
// - Data writes latch all bits; output pins drive the latched level.
// - Reset clears data, makes pins undriven inputs, pull-ups off.
module spp_port
  import spp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  // Register bus
  input  spp_bus_req_t             bus_in,
  output logic [SPP_DW-1:0]        rdata_out,
  // Pads
  input  wire logic [SPP_PINS-1:0] pin_in,
  output logic [SPP_PINS-1:0]      pin_out,
  output logic [SPP_PINS-1:0]      pin_oe_out,
  output logic [SPP_PINS-1:0]      pull_up_out,
  output logic [SPP_PINS-1:0]      pull_down_out,
  output logic [SPP_PINS-1:0]      slew_out,
  output logic [SPP_PINS-1:0]      drive_hi_out
);
  import spp_pkg::*;

  logic [SPP_PINS-1:0] data_q, data_d;
  logic [SPP_PINS-1:0] dir_q, dir_d;
  logic [SPP_PINS-1:0] pull_q, pull_d;
  logic [SPP_PINS-1:0] slew_q, slew_d;
  logic [SPP_PINS-1:0] drive_q, drive_d;
  logic [SPP_PINS-1:0] irqpd_q, irqpd_d;
  logic [SPP_DW-1:0]   rdata_q, rdata_d;
  spp_pad_ctl_t        pad_d, pad_q;
  logic [SPP_PINS-1:0] pin_sync;

  function automatic logic [SPP_DW-1:0] zext(input logic [SPP_PINS-1:0] v);
    zext = {{(SPP_DW-SPP_PINS){1'b0}}, v};
  endfunction : zext

  // Pin bits ride in the low lanes of the data word
  if (SPP_DW < SPP_PINS) begin : g_lane_check
    $error("spp_port needs SPP_DW of at least SPP_PINS");
  end

  spp_sync #(.W(SPP_PINS)) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Register writes
  always_comb begin
    data_d  = data_q;
    dir_d   = dir_q;
    pull_d  = pull_q;
    slew_d  = slew_q;
    drive_d = drive_q;
    irqpd_d = irqpd_q;
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        SPP_A_DATA:   data_d  = bus_in.wdata[SPP_PINS-1:0];
        SPP_A_DIR:    dir_d   = bus_in.wdata[SPP_PINS-1:0];
        SPP_A_PULL:   pull_d  = bus_in.wdata[SPP_PINS-1:0];
        SPP_A_SLEW:   slew_d  = bus_in.wdata[SPP_PINS-1:0];
        SPP_A_DRIVE:  drive_d = bus_in.wdata[SPP_PINS-1:0];
        SPP_A_IRQCFG: irqpd_d = bus_in.wdata[SPP_PINS-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; pin level only for inputs
  always_comb begin
    rdata_d = SPP_RD_NONE;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        SPP_A_DATA:   rdata_d = zext((data_q & dir_q) | (pin_sync & ~dir_q));
        SPP_A_DIR:    rdata_d = zext(dir_q);
        SPP_A_PULL:   rdata_d = zext(pull_q);
        SPP_A_SLEW:   rdata_d = zext(slew_q);
        SPP_A_DRIVE:  rdata_d = zext(drive_q);
        SPP_A_IRQCFG: rdata_d = zext(irqpd_q);
        default:      rdata_d = SPP_RD_NONE;
      endcase
    end
  end

  spp_pad_map u_map (
    .data_in   (data_d),
    .dir_in    (dir_d),
    .pull_in   (pull_d),
    .slew_in   (slew_d),
    .drive_in  (drive_d),
    .irq_pd_in (irqpd_d),
    .pad_out   (pad_d)
  );

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_q  <= SPP_RST_ZERO;
      dir_q   <= SPP_RST_ZERO;
      pull_q  <= SPP_RST_ZERO;
      slew_q  <= SPP_RST_SLEW;
      drive_q <= SPP_RST_ZERO;
      irqpd_q <= SPP_RST_ZERO;
      rdata_q <= SPP_RD_NONE;
      pad_q   <= '0;
    end else begin
      data_q  <= data_d;
      dir_q   <= dir_d;
      pull_q  <= pull_d;
      slew_q  <= slew_d;
      drive_q <= drive_d;
      irqpd_q <= irqpd_d;
      rdata_q <= rdata_d;
      pad_q   <= pad_d;
    end
  end

  assign rdata_out     = rdata_q;
  assign pin_out       = pad_q.out_val;
  assign pin_oe_out    = pad_q.out_en;
  assign pull_up_out   = pad_q.pull_up;
  assign pull_down_out = pad_q.pull_down;
  assign slew_out      = pad_q.slew;
  assign drive_hi_out  = pad_q.drive_hi;

  a_oe_follows_dir: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_oe_out == dir_q) else $error("output enable differs from direction");
  a_out_pull_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (pin_oe_out & (pull_up_out | pull_down_out)) == '0) else $error("pull on while driving");
  a_pullup_input: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pull_up_out == (pull_q & ~dir_q & ~irqpd_q)) else $error("pull-up wrong");
  a_pulldown_irq: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (pull_down_out & ~irqpd_q) == '0) else $error("pull-down without interrupt select");
  a_slew_output: assert property (@(posedge clk_in) disable iff (!nrst_in)
    slew_out == (slew_q & dir_q)) else $error("slew control wrong");
  a_drive_output: assert property (@(posedge clk_in) disable iff (!nrst_in)
    drive_hi_out == (drive_q & dir_q)) else $error("drive select wrong");
  a_data_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_in.wr && bus_in.addr == SPP_A_DATA |=> data_q == $past(bus_in.wdata[SPP_PINS-1:0]))
    else $error("data write not latched");
  a_read_output: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_in.rd && bus_in.addr == SPP_A_DATA && !bus_in.wr |=>
      ((rdata_out[SPP_PINS-1:0] ^ $past(data_q)) & $past(dir_q)) == '0)
    else $error("output bit read not from latch");
  a_drive_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ((drive_q == '0) |-> (drive_hi_out == '0))) else $error("high drive with bits zero");
  // No disable here: the pads must already be quiet while reset is held
  a_reset_quiet: assert property (@(posedge clk_in)
    !nrst_in |-> (pin_oe_out | pin_out | pull_up_out | pull_down_out | slew_out | drive_hi_out) == '0)
    else $error("pad control active in reset");
  a_read_input: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_in.rd && bus_in.addr == SPP_A_DATA && !bus_in.wr |=>
      ((rdata_out[SPP_PINS-1:0] ^ $past(pin_sync)) & ~$past(dir_q)) == '0)
    else $error("input bit read not from pin");
  a_dir_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_in.wr && bus_in.addr == SPP_A_DIR |=> pin_oe_out == $past(bus_in.wdata[SPP_PINS-1:0]))
    else $error("direction write not applied");
  a_pad_value: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_out == (data_q & dir_q)) else $error("pin output differs from latch");
  // Read data stands for one cycle only, so a late sampler sees zero
  a_read_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !bus_in.rd |=> rdata_out == SPP_RD_NONE) else $error("read data outside read slot");
  a_read_upper: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rdata_out[SPP_DW-1:SPP_PINS] == '0) else $error("unused read bits set");
  // Indices past the last register must not alias onto a real one
  a_unmapped_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_in.wr && bus_in.addr > SPP_A_IRQCFG |=> $stable({data_q, dir_q, pull_q, slew_q, drive_q, irqpd_q}))
    else $error("write to unused index changed a register");
endmodule : spp_port

// File: src/spp_sync.sv
`timescale 1ns/100ps
module spp_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // A zero-width stage cannot carry a pin
  if (W < 1) begin : g_w_check
    $error("spp_sync needs W of at least 1");
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : spp_sync

// File: test/spp_pad_model.sv
`timescale 1ns/100ps
module spp_pad_model (
  // Clock
  input  wire logic       clk_in,
  // Pad controls from the port
  input  wire logic [5:0] out_in,
  input  wire logic [5:0] oe_in,
  input  wire logic [5:0] pu_in,
  input  wire logic [5:0] pd_in,
  // Board side drive
  input  wire logic [5:0] ext_val_in,
  input  wire logic [5:0] ext_en_in,
  // Pin levels
  output logic      [5:0] lvl_out
);
  // Floating pins wander so a stale level never reads as valid
  logic wander = 1'b0;
  always @(posedge clk_in) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_in[i]) lvl_out[i] = out_in[i];
      else if (ext_en_in[i]) lvl_out[i] = ext_val_in[i];
      else if (pu_in[i]) lvl_out[i] = 1'b1;
      else if (pd_in[i]) lvl_out[i] = 1'b0;
      else lvl_out[i] = wander ^ i[0];
    end
  end
endmodule : spp_pad_model

// File: test/spp_port_test.sv
`timescale 1ns/100ps
module spp_port_test;
  import spp_pkg::*;
  logic         clk_in = 1'b0;
  logic         nrst_in = 1'b1;
  spp_bus_req_t bus_req = '0;
  logic [5:0]   lvl, pout, oe, pu, pd, slew, drv;
  logic [5:0]   ext_val = 6'h00;
  logic [5:0]   ext_en = 6'h00;
  logic [7:0]   rdata, got;
  int           err_count = 0;
  int           num_checks = 0;
  int           cycles = 0;
  always #12.5 clk_in = ~clk_in;
  spp_port spp_port_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus_req), .rdata_out(rdata),
    .pin_in(lvl), .pin_out(pout), .pin_oe_out(oe), .pull_up_out(pu), .pull_down_out(pd),
    .slew_out(slew), .drive_hi_out(drv));
  spp_pad_model spp_pad_model_i (.clk_in(clk_in), .out_in(pout), .oe_in(oe), .pu_in(pu), .pd_in(pd),
    .ext_val_in(ext_val), .ext_en_in(ext_en), .lvl_out(lvl));
  task results;
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_req.wr <= 1'b0;
    #1;
  endtask : bus_wr
  task bus_rd(input logic [2:0] a);
    @(posedge clk_in);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_req.rd <= 1'b0;
    #1;
    got = rdata;
  endtask : bus_rd
  task t_reset;
    chk("oe", 8'h00, {2'b00, oe});
    chk("pull", 8'h00, {2'b00, pu | pd});
    for (int a = 0; a < 6; a++) begin
      bus_rd(a[2:0]);
      if (a > 0) chk("reg", 8'h00, got);
    end
  endtask : t_reset
  task t_output;
    bus_wr(SPP_A_DATA, 8'hEA);
    chk("oe idle", 8'h00, {2'b00, oe});
    bus_wr(SPP_A_DIR, 8'h3F);
    chk("oe", 8'h3F, {2'b00, oe});
    chk("pin_out", 8'h2A, {2'b00, pout});
    bus_rd(SPP_A_DIR);
    chk("dir", 8'h3F, got);
    bus_rd(SPP_A_DATA);
    chk("data out", 8'h2A, got);
  endtask : t_output
  task t_input;
    bus_wr(SPP_A_DIR, 8'h30);
    bus_wr(SPP_A_PULL, 8'h3F);
    bus_wr(SPP_A_IRQCFG, 8'h02);
    chk("pull_up", 8'h0D, {2'b00, pu});
    chk("pull_down", 8'h02, {2'b00, pd});
    ext_val <= 6'h05;
    ext_en <= 6'h0D;
    repeat (3) @(posedge clk_in);
    bus_rd(SPP_A_DATA);
    chk("data in", 8'h25, got);
    bus_wr(SPP_A_IRQCFG, 8'h00);
    repeat (3) @(posedge clk_in);
    bus_rd(SPP_A_DATA);
    chk("data pulled", 8'h27, got);
    chk("pull_down off", 8'h00, {2'b00, pd});
  endtask : t_input
  task t_pad;
    bus_wr(SPP_A_SLEW, 8'h3F);
    chk("slew", 8'h30, {2'b00, slew});
    bus_wr(SPP_A_DRIVE, 8'h15);
    chk("drive", 8'h10, {2'b00, drv});
    bus_wr(3'h6, 8'hFF);
    bus_rd(3'h6);
    chk("unmapped", SPP_RD_NONE, got);
    bus_rd(SPP_A_DIR);
    chk("dir kept", 8'h30, got);
  endtask : t_pad
  task t_rerun;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("oe rst", 8'h00, {2'b00, oe});
    chk("pads rst", 8'h00, {2'b00, pout | pu | pd | slew | drv});
    @(posedge clk_in);
    nrst_in <= 1'b1;
    bus_rd(SPP_A_PULL);
    chk("pull rst", 8'h00, got);
    @(posedge clk_in);
    #1;
    chk("rdata idle", SPP_RD_NONE, rdata);
  endtask : t_rerun
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      results();
    end
  end
  initial begin
    nrst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    t_reset();
    t_output();
    t_input();
    t_pad();
    t_rerun();
    results();
  end
endmodule : spp_port_test
